//--- bench/dac_channel_enable_control_tb.sv
// Self-checking bench of the converter enable control
`include "dcec_map.svh"
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t %s", $time, m); end end
module dac_channel_enable_control_tb
  import dcec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       MCLK, RST_B, CE, WR, RD, c1, c0, a1, a0;
  logic [19:0] ADDR;
  dcec_byte_t WDATA, RDATA, CH1_VALUE, lvl1, lvl0, d;
  int         bad_count = 0;
  int         cmp_count = 0;
  // Conversion truth tables, bit i indexed by {ch1 enable, ch0 enable, shared enable}
  localparam logic [7:0] conv1_tab = 8'hF8;
  localparam logic [7:0] conv0_tab = 8'hEC;
  dcec_top dut (.MCLK(MCLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CH1_VALUE(CH1_VALUE), .CH1_CONV_EN(c1), .CH0_CONV_EN(c0),
    .ANALOG_OUT_CH1_EN(a1), .ANALOG_OUT_CH0_EN(a0));
  dcec_conv_model m1 (.clk(MCLK), .rst_b(RST_B), .conv_en(c1), .out_en(a1), .value(CH1_VALUE),
    .level(lvl1));
  dcec_conv_model m0 (.clk(MCLK), .rst_b(RST_B), .conv_en(c0), .out_en(a0), .value(8'h00),
    .level(lvl0));
  // ------------------------------------------------------------
  // Bus cycles and closing report
  // ------------------------------------------------------------
  task automatic wr(input logic [19:0] a, input dcec_byte_t v);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Reset values of both registers and of the enables
  task automatic t_reset;
    rd(`DCEC_OFF_CONTROL);
    `CHK(d, 8'h1F, "control reset")
    rd(`DCEC_OFF_CH1_VALUE);
    `CHK(d, 8'h00, "value reset")
    `CHK({c1, c0, a1, a0}, 4'h0, "enables at reset")
  endtask : t_reset
  // Every combination of the three control bits, low bits written as zero
  task automatic t_table;
    for (int i = 0; i < 8; i++)
    begin
      wr(`DCEC_OFF_CONTROL, {i[2:0], 5'h00});
      @(posedge MCLK);
      #1;
      `CHK(c1, conv1_tab[i], "ch1 convert")
      `CHK(c0, conv0_tab[i], "ch0 convert")
      `CHK(a1, i[2], "ch1 pin")
      `CHK(a0, i[1], "ch0 pin")
      rd(`DCEC_OFF_CONTROL);
      `CHK(d, {i[2:0], 5'h1F}, "control readback")
      if (i[2])
        `CHK(lvl1, 8'h00, "ch1 level")
      if (i[1])
        `CHK(lvl0, 8'h00, "ch0 level")
    end
  endtask : t_table
  // Channel 1 data reaches its pin once enabled; frozen and unmapped cycles
  task automatic t_value;
    wr(`DCEC_OFF_CH1_VALUE, 8'h5A);
    wr(`DCEC_OFF_CONTROL, 8'h80);
    repeat (2) @(posedge MCLK);
    #1;
    `CHK(lvl1, 8'h5A, "ch1 level")
    `CHK(CH1_VALUE, 8'h5A, "ch1 value")
    d = lvl0;
    @(posedge MCLK);
    CE <= 1'b0;
    #1;
    `CHK(lvl0, ~d, "ch0 released")
    wr(`DCEC_OFF_CH1_VALUE, 8'hC3);
    CE <= 1'b1;
    rd(`DCEC_OFF_CH1_VALUE);
    `CHK(d, 8'h5A, "frozen write")
    rd(20'h00000);
    `CHK(d, 8'hFF, "unmapped read")
    @(posedge MCLK);
    #1;
    `CHK(RDATA, 8'h00, "read data cleared")
  endtask : t_value
  // Reset in mid-run brings every register and enable back
  task automatic t_rerun;
    @(posedge MCLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    `CHK({CH1_VALUE, RDATA}, 16'h0000, "values in reset")
    `CHK({c1, c0, a1, a0}, 4'h0, "enables in reset")
    @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_reset();
  endtask : t_rerun
  // Clock, and a watchdog that cuts a hang short
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  initial
  begin
    repeat (5000) @(posedge MCLK);
    bad_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    RST_B = 1'b0;
    CE = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 20'h00000;
    WDATA = 8'h00;
    repeat (12) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge MCLK);
    t_reset();
    t_table();
    t_value();
    t_rerun();
    summarize();
  end
endmodule : dac_channel_enable_control_tb
`default_nettype wire

//--- bench/dcec_conv_model.sv
// Behavioural converter core as seen at its analog output pin
`default_nettype none
module dcec_conv_model
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       conv_en,
  input  wire logic       out_en,
  input  wire logic [7:0] value,
  output var  logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin toggles so that a stale level never passes for a driven one;
  // reset gives the toggling a known start
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      level <= 8'h00;
    else
      level <= (conv_en && out_en) ? value : ~level;
  end
endmodule : dcec_conv_model
`default_nettype wire

//--- include/dcec_map.svh
// Register map, field positions and reset values of the converter enable control
`ifndef DCEC_MAP_SVH
`define DCEC_MAP_SVH

`define DCEC_ADDR_W          20
`define DCEC_OFF_CONTROL     20'hFFF9E
`define DCEC_OFF_CH1_VALUE   20'hFFF9D
`define DCEC_BIT_CH1_OE      7
`define DCEC_BIT_CH0_OE      6
`define DCEC_BIT_SHARED_EN   5
`define DCEC_CTRL_RW_MASK    8'hE0
`define DCEC_CTRL_RO_ONES    8'h1F
`define DCEC_CTRL_RESET      8'h1F
`define DCEC_CH1_RESET       8'h00
`define DCEC_UNMAPPED_READ   8'hFF

`endif

//--- include/dcec_pkg.sv
// Types shared by the converter enable control design
`default_nettype none
package dcec_pkg;
  typedef logic [7:0] dcec_byte_t;
endpackage : dcec_pkg
`default_nettype wire

//--- src/dcec_enable_decode.sv
// Decoder from control bits to per-channel conversion and output enables
`default_nettype none
module dcec_enable_decode
  import dcec_pkg::*;
(
  input  wire logic ch1_oe,
  input  wire logic ch0_oe,
  input  wire logic shared_en,
  output logic      ch1_conv,
  output logic      ch0_conv,
  output logic      ch1_out,
  output logic      ch0_out
);
  // ---------------------------------------------------------------
  // Enable table
  // ---------------------------------------------------------------
  // A lone enable pulls the other channel in only when sharing is on
  always_comb
  begin
    ch1_conv = ch1_oe | (ch0_oe & shared_en);
    ch0_conv = ch0_oe | (ch1_oe & shared_en);
    ch1_out  = ch1_oe;
    ch0_out  = ch0_oe;
  end
endmodule : dcec_enable_decode
`default_nettype wire

//--- src/dcec_top.sv
// Two-channel converter enable control with its register port
//
// Functional notes
// - Control bit 7 enables channel 1 conversion and its analog output.
// - Control bit 6 enables channel 0 conversion and its analog output.
// - Both output enable bits clear: no channel converts, shared bit ignored.
// - Shared bit clear, one enable set: only that channel converts.
// - Shared bit set, any enable set: both channels convert.
//
// The plain strobed port was decided locally.
`include "dcec_map.svh"
`default_nettype none
module dcec_top
  import dcec_pkg::*;
(
  input  wire logic                    MCLK,
  input  wire logic                    RST_B,
  input  wire logic                    CE,
  input  wire logic [`DCEC_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]              WDATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic      [7:0]              RDATA,
  output logic      [7:0]              CH1_VALUE,
  output logic                         CH1_CONV_EN,
  output logic                         CH0_CONV_EN,
  output logic                         ANALOG_OUT_CH1_EN,
  output logic                         ANALOG_OUT_CH0_EN
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // First and second stage of the reset release
  logic rst_s1_q;
  logic rst_b_q;

  // Asynchronous assert, synchronous release through two stages
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_s1_q <= 1'b0;
      rst_b_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_b_q  <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Stored control, channel 1 data and the registered read word
  dcec_byte_t ctrl_q;
  dcec_byte_t ctrl_d;
  dcec_byte_t ch1_q;
  dcec_byte_t ch1_d;
  dcec_byte_t rdata_q;
  dcec_byte_t rdata_d;

  // Address compare shared by the write, read and check paths
  function automatic logic hit(input logic [`DCEC_ADDR_W-1:0] a,
                               input logic [`DCEC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Control writes store only the three live bits; low bits are forced to ones
  always_comb
  begin
    ctrl_d  = ctrl_q;
    ch1_d   = ch1_q;
    rdata_d = rdata_q;
    if (WR && hit(ADDR, `DCEC_OFF_CONTROL))
      ctrl_d = (WDATA & `DCEC_CTRL_RW_MASK) | `DCEC_CTRL_RO_ONES;
    if (WR && hit(ADDR, `DCEC_OFF_CH1_VALUE))
      ch1_d = WDATA;
    if (RD)
    begin
      if (hit(ADDR, `DCEC_OFF_CONTROL))
        rdata_d = ctrl_q | `DCEC_CTRL_RO_ONES;
      else if (hit(ADDR, `DCEC_OFF_CH1_VALUE))
        rdata_d = ch1_q;
      else
        rdata_d = `DCEC_UNMAPPED_READ;
    end
    else
      rdata_d = '0; // Read data only stands in the cycle after a read
  end

  // Registers only; a low clock enable freezes them, strobes included
  always_ff @(posedge MCLK or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      ctrl_q  <= `DCEC_CTRL_RESET;
      ch1_q   <= `DCEC_CH1_RESET;
      rdata_q <= '0;
    end
    else if (CE)
    begin
      ctrl_q  <= ctrl_d;
      ch1_q   <= ch1_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Channel enables
  // ---------------------------------------------------------------
  // Decoded enables before they are registered
  logic ch1_conv;
  logic ch0_conv;
  logic ch1_out;
  logic ch0_out;
  logic [3:0] en_q;
  logic [3:0] en_d;

  // Pure table from the three live control bits to the four enables
  dcec_enable_decode u_decode (
    .ch1_oe    (ctrl_q[`DCEC_BIT_CH1_OE]),
    .ch0_oe    (ctrl_q[`DCEC_BIT_CH0_OE]),
    .shared_en (ctrl_q[`DCEC_BIT_SHARED_EN]),
    .ch1_conv  (ch1_conv),
    .ch0_conv  (ch0_conv),
    .ch1_out   (ch1_out),
    .ch0_out   (ch0_out)
  );

  // Registered so every output leaves a flip-flop; costs one cycle of lag
  always_comb
  begin
    en_d = {ch1_conv, ch0_conv, ch1_out, ch0_out};
  end

  // Enables fall to off in reset so no pin is driven before software asks
  always_ff @(posedge MCLK or negedge rst_b_q)
  begin
    if (!rst_b_q)
      en_q <= '0;
    else if (CE)
      en_q <= en_d;
  end

  // Every output is a plain flop copy
  assign CH1_CONV_EN       = en_q[3];
  assign CH0_CONV_EN       = en_q[2];
  assign ANALOG_OUT_CH1_EN = en_q[1];
  assign ANALOG_OUT_CH0_EN = en_q[0];
  assign CH1_VALUE         = ch1_q;
  assign RDATA             = rdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_ch1_follow: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    CE |=> ANALOG_OUT_CH1_EN == $past(ctrl_q[`DCEC_BIT_CH1_OE]))
    else $error("Channel 1 output enable does not follow control bit");
  a_ch0_follow: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    CE |=> ANALOG_OUT_CH0_EN == $past(ctrl_q[`DCEC_BIT_CH0_OE]))
    else $error("Channel 0 output enable does not follow control bit");
  a_both_off: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && !ctrl_q[`DCEC_BIT_CH1_OE] && !ctrl_q[`DCEC_BIT_CH0_OE])
      |=> (!CH1_CONV_EN && !CH0_CONV_EN))
    else $error("Conversion enabled with both output enables clear");
  a_single_only: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && !ctrl_q[`DCEC_BIT_SHARED_EN]
        && (ctrl_q[`DCEC_BIT_CH1_OE] != ctrl_q[`DCEC_BIT_CH0_OE]))
      |=> (CH1_CONV_EN == ANALOG_OUT_CH1_EN) && (CH0_CONV_EN == ANALOG_OUT_CH0_EN))
    else $error("Unselected channel converts without shared enable");
  a_shared_both: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && ctrl_q[`DCEC_BIT_SHARED_EN]
        && (ctrl_q[`DCEC_BIT_CH1_OE] || ctrl_q[`DCEC_BIT_CH0_OE]))
      |=> (CH1_CONV_EN && CH0_CONV_EN))
    else $error("Shared enable did not start both channels");
  a_dual_on: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && ctrl_q[`DCEC_BIT_CH1_OE] && ctrl_q[`DCEC_BIT_CH0_OE])
      |=> (CH1_CONV_EN && CH0_CONV_EN))
    else $error("Both enables set but a channel is idle");
  a_low_ones: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && RD && hit(ADDR, `DCEC_OFF_CONTROL))
      |=> (RDATA & `DCEC_CTRL_RO_ONES) == `DCEC_CTRL_RO_ONES)
    else $error("Unused control bits did not read as one");
  a_write_ctrl: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && WR && hit(ADDR, `DCEC_OFF_CONTROL))
      |=> ctrl_q == ((($past(WDATA)) & `DCEC_CTRL_RW_MASK) | `DCEC_CTRL_RO_ONES))
    else $error("Control write stored wrong value");

  // ---------------------------------------------------------------
  // Further checks on single channels, reads and the clock enable
  // ---------------------------------------------------------------
  // A set channel 1 bit must start both its conversion and its pin
  a_ch1_conv_on: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && ctrl_q[`DCEC_BIT_CH1_OE])
      |=> (CH1_CONV_EN && ANALOG_OUT_CH1_EN))
    else $error("Channel 1 enable bit set but channel 1 idle");

  // A set channel 0 bit must start both its conversion and its pin
  a_ch0_conv_on: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && ctrl_q[`DCEC_BIT_CH0_OE])
      |=> (CH0_CONV_EN && ANALOG_OUT_CH0_EN))
    else $error("Channel 0 enable bit set but channel 0 idle");

  // Lone channel 1 enable without sharing keeps channel 0 quiet
  a_single_ch1: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && !ctrl_q[`DCEC_BIT_SHARED_EN] && ctrl_q[`DCEC_BIT_CH1_OE]
        && !ctrl_q[`DCEC_BIT_CH0_OE]) |=> (CH1_CONV_EN && !CH0_CONV_EN))
    else $error("Lone channel 1 enable did not convert alone");

  // Lone channel 0 enable without sharing keeps channel 1 quiet
  a_single_ch0: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && !ctrl_q[`DCEC_BIT_SHARED_EN] && ctrl_q[`DCEC_BIT_CH0_OE]
        && !ctrl_q[`DCEC_BIT_CH1_OE]) |=> (CH0_CONV_EN && !CH1_CONV_EN))
    else $error("Lone channel 0 enable did not convert alone");

  // Whole control readback, live bits and forced ones together
  a_read_ctrl: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && RD && hit(ADDR, `DCEC_OFF_CONTROL))
      |=> RDATA == ($past(ctrl_q) | `DCEC_CTRL_RO_ONES))
    else $error("Control readback differs from stored value");

  // Read data must not linger; a stale word could pass for a fresh read
  a_rdata_idle: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    (CE && !RD) |=> RDATA == 8'h00)
    else $error("Read data stands outside the cycle after a read");

  // A low clock enable holds every output, read data included
  a_freeze_hold: assert property (@(posedge MCLK) disable iff (!rst_b_q)
    !CE |=> $stable({CH1_CONV_EN, CH0_CONV_EN, ANALOG_OUT_CH1_EN, ANALOG_OUT_CH0_EN})
      && $stable(CH1_VALUE) && $stable(RDATA))
    else $error("Outputs moved while the clock enable was low");
endmodule : dcec_top
`default_nettype wire
